// file: rtl/csw_pkg.sv
// constants, types and register layout of the clock switch and reset sequencer
package csw_pkg;

  localparam int CLK_MHZ = 50;
  localparam int CLK_KHZ = 50000;

  // power-up delays, times as printed, cycles derived from the clock rate
  localparam int BIAS_SETTLE_US = 10;
  localparam int BIAS_SETTLE_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam int POWER_UP_DELAY_TIMER_SHORT_MS = 4;
  localparam int POWER_UP_DELAY_TIMER_MID_MS = 16;
  localparam int POWER_UP_DELAY_TIMER_LONG_MS = 64;
  localparam int POWER_UP_DELAY_TIMER_SHORT_CYC = POWER_UP_DELAY_TIMER_SHORT_MS * CLK_KHZ;
  localparam int POWER_UP_DELAY_TIMER_MID_CYC = POWER_UP_DELAY_TIMER_MID_MS * CLK_KHZ;
  localparam int POWER_UP_DELAY_TIMER_LONG_CYC = POWER_UP_DELAY_TIMER_LONG_MS * CLK_KHZ;
  localparam int TIMER_W = 22;
  localparam int MASTER_CLEAR_PIN_FILTER_CYC = 8;
  localparam int FAIL_LOW_POWER_RC_OSC_TICKS = 4;

  // register byte addresses
  localparam logic [31:0] OSC_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] RESET_CAUSE_ADDR = 32'h0000_0004;
  localparam logic [31:0] SEQ_STATUS_ADDR = 32'h0000_0008;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_OSC = 2'h1;
  localparam logic [1:0] SEL_CAUSE = 2'h2;
  localparam logic [1:0] SEL_STATUS = 2'h3;

  // oscillator control fields
  localparam int CURRENT_OSC_GROUP_LSB = 12;
  localparam int NEW_OSC_GROUP_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int OSC_SWITCH_ENABLE_BIT = 0;
  localparam logic [15:0] OSC_CTRL_RESET = 16'h0000;

  // unlock keys
  localparam logic [7:0] KEY_LO1 = 8'h46;
  localparam logic [7:0] KEY_LO2 = 8'h57;
  localparam logic [7:0] KEY_HI1 = 8'h78;
  localparam logic [7:0] KEY_HI2 = 8'h9A;
  localparam logic [1:0] UNL_IDLE = 2'h0;
  localparam logic [1:0] UNL_KEY1 = 2'h1;
  localparam logic [1:0] UNL_OPEN = 2'h2;

  // reset cause fields
  localparam int CAUSE_TRAP = 15;
  localparam int CAUSE_IOP = 14;
  localparam int CAUSE_EXT = 7;
  localparam int CAUSE_SWR = 6;
  localparam int CAUSE_WDTO = 4;
  localparam int CAUSE_SLEEP = 3;
  localparam int CAUSE_IDLE = 2;
  localparam int CAUSE_BOR = 1;
  localparam int CAUSE_POR = 0;
  localparam logic [15:0] CAUSE_RESET = 16'h0000;

  localparam logic [1:0] SMS_BOTH = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GRP_SECONDARY = 2'h0,
    GRP_FRC       = 2'h1,
    GRP_LOW_POWER_RC_OSC      = 2'h2,
    GRP_PRIMARY   = 2'h3
  } csw_group_t;

  typedef enum logic [5:0] {
    RS_HOLD = 6'h01,
    RS_BIAS = 6'h02,
    RS_POWER_UP_DELAY_TIMER = 6'h04,
    RS_Q1   = 6'h08,
    RS_CLK  = 6'h10,
    RS_RUN  = 6'h20
  } csw_seq_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } csw_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } csw_axi_rsp_t;

  typedef struct packed {
    logic [1:0] osc_group;
    logic [3:0] primary_mode;
    logic [1:0] switch_monitor;
    logic [1:0] power_up_delay_timer_sel;
    logic       wdt_enable;
  } csw_cfg_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic wdt_timeout;
    logic wdt_wakeup;
    logic reset_instr;
    logic trap_conflict;
    logic illegal_op;
  } csw_rst_evt_t;

  typedef struct packed {
    logic       sysclk_tick;
    logic       low_power_rc_osc_tick;
    logic       osc_running;
    logic       ost_done;
    logic       pll_used;
    logic       pll_lock;
    logic [3:0] group_ready;
  } csw_osc_stat_t;

endpackage

// file: rtl/csw_pin_filter.sv
// noise filter: output follows the pin only after it stays stable for n cycles
`timescale 1ns/1ns
module csw_pin_filter
  import csw_pkg::*;
#(
  parameter int N = MASTER_CLEAR_PIN_FILTER_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic raw,
  output logic      filt
);

  if (N < 2 || N > 255) begin : g_chk
    $error("csw_pin_filter: N out of range");
  end

  logic [7:0] cnt;
  wire        differs = raw != filt;
  wire        settled = cnt == 8'(N - 1);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt  <= 8'h00;
      filt <= 1'b1;
    end else if (!differs) begin
      cnt <= 8'h00;
    end else if (settled) begin
      cnt  <= 8'h00;
      filt <= raw;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

endmodule

// file: rtl/csw_delay_timer.sv
// loadable down counter that pulses done when the loaded count has elapsed
`timescale 1ns/1ns
module csw_delay_timer
  import csw_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              done
);

  if (W < 4) begin : g_chk
    $error("csw_delay_timer: W too small");
  end

  logic [W-1:0] cnt;
  logic         busy;
  wire          last = busy && cnt == W'(1);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= last && !start;
      if (start) begin
        cnt  <= load;
        busy <= load != '0;
      end else if (busy) begin
        cnt  <= cnt - W'(1);
        busy <= !last;
      end
    end
  end

endmodule

// file: rtl/csw_clock_reset.sv
// clock group switching, fail-safe monitor, reset cause and power-up sequencing
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Overview of operation
// - low-power osc on at power-up, then conditional
// - monitor enabled keeps low-power osc on, except Sleep
// - failure raises trap, system moves to fast RC
// - failure loads fast RC, sets fail, clears switch
// - failure leaves watchdog clock running
// - oscillator not ready after power-up timers: trap
// - four groups, switch between groups only
// - current group read-only, new group writable, status bits
// - power and brown-out reset load both group fields
// - switch enable starts transition, clearing aborts it
// - config 1x disables switching and monitor
// - switching disabled: config selects, current group mirrors
// - low byte write needs keys 0x46 then 0x57
// - high byte write needs keys 0x78 then 0x9A
// - reset causes recorded in status bits
// - watchdog wake-up is not a reset
// - reset pin filtered against short pulses
// - internal resets never drive reset pin
// - bias settle 10 us then 0/4/16/64 ms delay
// - release system reset on next first quarter phase
// - fast exit; without monitor wait for clock
// - group code 01 runs fast RC
module csw_clock_reset
  import csw_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_SHORT = POWER_UP_DELAY_TIMER_SHORT_CYC,
  parameter int POWER_UP_DELAY_TIMER_MID   = POWER_UP_DELAY_TIMER_MID_CYC,
  parameter int POWER_UP_DELAY_TIMER_LONG  = POWER_UP_DELAY_TIMER_LONG_CYC,
  parameter int FAIL_TICKS = FAIL_LOW_POWER_RC_OSC_TICKS,
  parameter int MASTER_CLEAR_PIN_CYC   = MASTER_CLEAR_PIN_FILTER_CYC
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire csw_axi_req_t  axi_req,
  output csw_axi_rsp_t       axi_rsp,
  input  wire csw_cfg_t      cfg,
  input  wire csw_rst_evt_t  rst_evt,
  input  wire csw_osc_stat_t osc_stat,
  input  wire logic          master_clear_pin_n,
  input  wire logic          first_quarter_phase,
  input  wire logic          sleep_mode,
  input  wire logic          idle_mode,
  input  wire logic          soft_watchdog_enable,
  output logic               master_clear_pin_oe,
  output logic               low_power_rc_osc_en,
  output logic [1:0]         sel_group,
  output logic [3:0]         sel_primary_mode,
  output logic               clock_fail_trap,
  output logic               system_reset_n
);

  if (POWER_UP_DELAY_TIMER_LONG >= (1 << TIMER_W) || POWER_UP_DELAY_TIMER_SHORT < 1 || FAIL_TICKS < 2
      || FAIL_TICKS > 255) begin : g_chk
    $error("csw_clock_reset: parameter out of range");
  end

  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    if (w == OSC_CTRL_ADDR) return SEL_OSC;
    else if (w == RESET_CAUSE_ADDR) return SEL_CAUSE;
    else if (w == SEQ_STATUS_ADDR) return SEL_STATUS;
    else return SEL_NONE;
  endfunction

  // key sequence step for one byte lane; any other write breaks it
  function automatic logic [1:0] unlock_step(input logic [1:0] st, input logic wr,
                                             input logic [7:0] d, input logic [7:0] k1,
                                             input logic [7:0] k2);
    if (!wr || st == UNL_OPEN) return UNL_IDLE;
    else if (d == k1) return UNL_KEY1;
    else if (st == UNL_KEY1 && d == k2) return UNL_OPEN;
    else return UNL_IDLE;
  endfunction

  // ---------------- bus slave ----------------
  logic        aw_hold;
  logic        w_hold;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  wire       do_write = aw_hold && w_hold && !axi_rsp.bvalid;
  wire [1:0] wsel = reg_sel(awaddr_q);
  wire [1:0] rsel = reg_sel(axi_req.araddr);
  wire       wr_osc = do_write && wsel == SEL_OSC;
  wire       wr_cause = do_write && wsel == SEL_CAUSE;
  wire       lo_wr = wr_osc && wstrb_q[0];
  wire       hi_wr = wr_osc && wstrb_q[1];

  // ---------------- state ----------------
  csw_seq_t    state;
  csw_seq_t    next_state;
  logic [1:0]  current_osc_group;
  logic [1:0]  new_osc_group;
  logic        osc_switch_enable;
  logic        clock_fail;
  logic [1:0]  lo_stage;
  logic [1:0]  hi_stage;
  logic [15:0] cause;
  logic [15:0] next_cause;
  logic [7:0]  fail_cnt;
  logic        por_pending;
  logic        master_clear_pin_prev;
  logic        master_clear_pin_f;
  logic        tmr_done;
  logic        tmr_start;
  logic [TIMER_W-1:0] tmr_load;

  wire mon_en = cfg.switch_monitor == SMS_BOTH;
  wire sw_en = !cfg.switch_monitor[1];
  wire por_evt = rst_evt.por || por_pending;
  wire pwr_evt = por_evt || rst_evt.bor;
  wire master_clear_pin_fall = master_clear_pin_prev && !master_clear_pin_f;
  wire warm_evt = master_clear_pin_fall || !master_clear_pin_f || rst_evt.wdt_timeout || rst_evt.reset_instr
                  || rst_evt.trap_conflict || rst_evt.illegal_op;

  // low-byte lane: switch enable; high-byte lane: new group
  wire lo_accept = lo_wr && lo_stage == UNL_OPEN;
  wire hi_accept = hi_wr && hi_stage == UNL_OPEN;

  wire [TIMER_W-1:0] power_up_delay_timer_len =
    cfg.power_up_delay_timer_sel == 2'h0 ? '0 :
    cfg.power_up_delay_timer_sel == 2'h1 ? TIMER_W'(POWER_UP_DELAY_TIMER_SHORT) :
    cfg.power_up_delay_timer_sel == 2'h2 ? TIMER_W'(POWER_UP_DELAY_TIMER_MID) : TIMER_W'(POWER_UP_DELAY_TIMER_LONG);

  wire timers_expired = tmr_done && (state == RS_POWER_UP_DELAY_TIMER || (state == RS_BIAS && power_up_delay_timer_len == '0));
  wire osc_group = current_osc_group == GRP_PRIMARY || current_osc_group == GRP_SECONDARY;
  wire osc_not_ready = !osc_stat.osc_running || !osc_stat.ost_done
                       || (osc_stat.pll_used && !osc_stat.pll_lock);
  wire start_fail = mon_en && timers_expired && osc_group && osc_not_ready;
  wire watch_run = mon_en && !sleep_mode && state == RS_RUN && current_osc_group != GRP_FRC;
  wire run_fail = watch_run && osc_stat.low_power_rc_osc_tick && !osc_stat.sysclk_tick
                  && fail_cnt == 8'(FAIL_TICKS - 1);
  wire fail = (start_fail || run_fail) && !pwr_evt;
  wire switch_done = osc_switch_enable && sw_en && !lo_accept && !fail
                     && (new_osc_group == current_osc_group || osc_stat.group_ready[new_osc_group]);
  wire wdt_on = cfg.wdt_enable || soft_watchdog_enable;
  wire power_up_delay_timer_running = state == RS_HOLD || state == RS_BIAS || state == RS_POWER_UP_DELAY_TIMER;
  // watchdog term is independent of failures, so its clock survives a trap
  wire next_low_power_rc_osc_en = power_up_delay_timer_running || (mon_en && !sleep_mode) || wdt_on
                      || current_osc_group == GRP_LOW_POWER_RC_OSC;

  // ---------------- power-up sequencer ----------------
  always_comb begin
    next_state = state;
    tmr_start = 1'b0;
    tmr_load = TIMER_W'(BIAS_SETTLE_CYC);
    case (state)
      RS_HOLD: begin
        next_state = RS_BIAS;
        tmr_start = 1'b1;
      end
      RS_BIAS: begin
        if (tmr_done && power_up_delay_timer_len == '0) begin
          next_state = RS_Q1;
        end else if (tmr_done) begin
          next_state = RS_POWER_UP_DELAY_TIMER;
          tmr_start = 1'b1;
          tmr_load = power_up_delay_timer_len;
        end
      end
      RS_POWER_UP_DELAY_TIMER: begin
        if (tmr_done) next_state = RS_Q1;
      end
      RS_Q1: begin
        // release on the quarter-phase edge, then to the reset vector
        if (first_quarter_phase && master_clear_pin_f) begin
          next_state = (mon_en || osc_stat.sysclk_tick) ? RS_RUN : RS_CLK;
        end
      end
      RS_CLK: begin
        if (osc_stat.sysclk_tick) next_state = RS_RUN;
      end
      RS_RUN: begin
        next_state = RS_RUN;
      end
      default: begin
        next_state = RS_HOLD;
      end
    endcase
    if (pwr_evt) begin
      next_state = RS_HOLD;
      tmr_start = 1'b0;
    end else if (warm_evt && state != RS_HOLD && state != RS_BIAS && state != RS_POWER_UP_DELAY_TIMER) begin
      next_state = RS_Q1;
    end
  end

  // ---------------- reset cause ----------------
  always_comb begin
    next_cause = cause;
    if (wr_cause && wstrb_q[0]) next_cause[7:0] = wdata_q[7:0];
    if (wr_cause && wstrb_q[1]) next_cause[15:8] = wdata_q[15:8];
    // hardware events are applied last so they win over a software write
    if (por_evt) begin
      next_cause = CAUSE_RESET;
      next_cause[CAUSE_POR] = 1'b1;
      next_cause[CAUSE_BOR] = 1'b1;
    end else begin
      if (rst_evt.bor) begin
        next_cause[CAUSE_POR] = 1'b0;
        next_cause[CAUSE_BOR] = 1'b1;
      end
      if (master_clear_pin_fall) begin
        next_cause[CAUSE_EXT] = 1'b1;
        next_cause[CAUSE_WDTO] = 1'b0;
        next_cause[CAUSE_SLEEP] = sleep_mode;
        next_cause[CAUSE_IDLE] = idle_mode;
        if (!sleep_mode && !idle_mode) next_cause[CAUSE_SWR] = 1'b0;
      end
      if (rst_evt.reset_instr || rst_evt.wdt_timeout) begin
        next_cause[CAUSE_EXT] = 1'b0;
        next_cause[CAUSE_SWR] = rst_evt.reset_instr;
        next_cause[CAUSE_WDTO] = rst_evt.wdt_timeout;
        next_cause[CAUSE_SLEEP] = 1'b0;
        next_cause[CAUSE_IDLE] = 1'b0;
      end
      // wake-up only marks the cause; the sequencer is left running
      if (rst_evt.wdt_wakeup) begin
        next_cause[CAUSE_WDTO] = 1'b1;
        next_cause[CAUSE_SLEEP] = 1'b1;
      end
      if (rst_evt.trap_conflict) next_cause[CAUSE_TRAP] = 1'b1;
      if (rst_evt.illegal_op) next_cause[CAUSE_IOP] = 1'b1;
    end
  end

  // ---------------- read mux ----------------
  logic [31:0] rd_word;
  logic [15:0] osc_rd;
  always_comb begin
    osc_rd = OSC_CTRL_RESET;
    osc_rd[CURRENT_OSC_GROUP_LSB+:2] = current_osc_group;
    osc_rd[NEW_OSC_GROUP_LSB+:2] = new_osc_group;
    osc_rd[LOCK_BIT] = osc_stat.pll_lock;
    osc_rd[CF_BIT] = clock_fail;
    osc_rd[OSC_SWITCH_ENABLE_BIT] = osc_switch_enable;
  end
  wire [31:0] status_rd = {22'h0, state, system_reset_n, low_power_rc_osc_en, mon_en, sw_en};
  assign rd_word = rsel == SEL_OSC ? {16'h0, osc_rd} :
                   rsel == SEL_CAUSE ? {16'h0, cause} :
                   rsel == SEL_STATUS ? status_rd : 32'h0000_0000;

  // ---------------- submodules ----------------
  csw_pin_filter #(
    .N (MASTER_CLEAR_PIN_CYC)
  ) u_master_clear_pin_filter (
    .clk  (clk),
    .rstn (rstn),
    .raw  (master_clear_pin_n),
    .filt (master_clear_pin_f)
  );

  csw_delay_timer #(
    .W (TIMER_W)
  ) u_delay (
    .clk   (clk),
    .rstn  (rstn),
    .start (tmr_start),
    .load  (tmr_load),
    .done  (tmr_done)
  );

  // ---------------- bus registers ----------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      axi_rsp  <= '0;
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      axi_rsp.awready <= !aw_hold && !(axi_req.awvalid && axi_rsp.awready);
      axi_rsp.wready  <= !w_hold && !(axi_req.wvalid && axi_rsp.wready);
      axi_rsp.arready <= !axi_rsp.rvalid && !(axi_req.arvalid && axi_rsp.arready);
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_hold  <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_hold  <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      if (do_write) begin
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp  <= wsel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end
      if (axi_rsp.bvalid && axi_req.bready) begin
        axi_rsp.bvalid  <= 1'b0;
        aw_hold         <= 1'b0;
        w_hold          <= 1'b0;
        axi_rsp.awready <= 1'b1;
        axi_rsp.wready  <= 1'b1;
      end
      if (axi_req.arvalid && axi_rsp.arready) begin
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rdata  <= rd_word;
        axi_rsp.rresp  <= rsel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end else if (axi_rsp.rvalid && axi_req.rready) begin
        axi_rsp.rvalid  <= 1'b0;
        axi_rsp.arready <= 1'b1;
      end
    end
  end

  // ---------------- control and status ----------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state       <= RS_HOLD;
      por_pending <= 1'b1;
      master_clear_pin_prev   <= 1'b1;
      cause       <= CAUSE_RESET;
      lo_stage    <= UNL_IDLE;
      hi_stage    <= UNL_IDLE;
      fail_cnt    <= 8'h00;
    end else begin
      state       <= next_state;
      por_pending <= 1'b0;
      master_clear_pin_prev   <= master_clear_pin_f;
      cause       <= next_cause;
      if (do_write) begin
        lo_stage <= unlock_step(lo_stage, lo_wr, wdata_q[7:0], KEY_LO1, KEY_LO2);
        hi_stage <= unlock_step(hi_stage, hi_wr, wdata_q[15:8], KEY_HI1, KEY_HI2);
      end
      if (!watch_run || osc_stat.sysclk_tick || fail) begin
        fail_cnt <= 8'h00;
      end else if (osc_stat.low_power_rc_osc_tick) begin
        fail_cnt <= fail_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      current_osc_group       <= GRP_FRC;
      new_osc_group       <= GRP_FRC;
      osc_switch_enable      <= 1'b0;
      clock_fail <= 1'b0;
    end else if (pwr_evt) begin
      current_osc_group       <= cfg.osc_group;
      new_osc_group       <= cfg.osc_group;
      osc_switch_enable      <= 1'b0;
      clock_fail <= 1'b0;
    end else begin
      if (!sw_en) begin
        current_osc_group <= cfg.osc_group;
      end else if (fail) begin
        current_osc_group <= GRP_FRC;
      end else if (switch_done) begin
        current_osc_group <= new_osc_group;
      end
      if (hi_accept && sw_en) new_osc_group <= wdata_q[NEW_OSC_GROUP_LSB+:2];
      if (fail || !sw_en) begin
        osc_switch_enable <= 1'b0;
      end else if (lo_accept) begin
        osc_switch_enable <= wdata_q[OSC_SWITCH_ENABLE_BIT];
      end else if (switch_done) begin
        osc_switch_enable <= 1'b0;
      end
      if (fail) clock_fail <= 1'b1;
    end
  end

  // ---------------- pin and clock outputs ----------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_clear_pin_oe <= 1'b0;
      low_power_rc_osc_en <= 1'b1;
      sel_group           <= GRP_FRC;
      sel_primary_mode    <= 4'h0;
      clock_fail_trap     <= 1'b0;
      system_reset_n      <= 1'b0;
    end else begin
      master_clear_pin_oe <= 1'b0;
      low_power_rc_osc_en <= next_low_power_rc_osc_en;
      sel_group           <= fail ? GRP_FRC : current_osc_group;
      sel_primary_mode    <= cfg.primary_mode;
      clock_fail_trap     <= fail;
      system_reset_n      <= next_state == RS_RUN;
    end
  end

endmodule

// file: test/csw_clock_reset_props.sv
// port assertions for the clock switch, fail-safe monitor and reset sequencer
`timescale 1ns/1ns
module csw_clock_reset_props
  import csw_pkg::*;
(
  input wire logic          clk,
  input wire logic          rstn,
  input wire csw_axi_req_t  axi_req,
  input wire csw_axi_rsp_t  axi_rsp,
  input wire csw_cfg_t      cfg,
  input wire csw_rst_evt_t  rst_evt,
  input wire csw_osc_stat_t osc_stat,
  input wire logic          master_clear_pin_n,
  input wire logic          first_quarter_phase,
  input wire logic          sleep_mode,
  input wire logic          idle_mode,
  input wire logic          soft_watchdog_enable,
  input wire logic          master_clear_pin_oe,
  input wire logic          low_power_rc_osc_en,
  input wire logic [1:0]    sel_group,
  input wire logic [3:0]    sel_primary_mode,
  input wire logic          clock_fail_trap,
  input wire logic          system_reset_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_pin_oe; !master_clear_pin_oe; endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("reset pin driven");
  property p_trap_frc; clock_fail_trap |-> sel_group == GRP_FRC; endproperty
  a_trap_frc: assert property (p_trap_frc) else $error("trap without fast rc");
  property p_low_power_rc_osc_on; (cfg.switch_monitor == SMS_BOTH && !sleep_mode) [*2] |-> low_power_rc_osc_en;
  endproperty
  a_low_power_rc_osc_on: assert property (p_low_power_rc_osc_on) else $error("low power osc off");
  property p_q1; $rose(system_reset_n) |-> $past(first_quarter_phase)
    || $past(first_quarter_phase, 2) || $past(first_quarter_phase, 3); endproperty
  a_q1: assert property (p_q1) else $error("release off phase");
  property p_swr; rst_evt.reset_instr |=> !system_reset_n; endproperty
  a_swr: assert property (p_swr) else $error("reset instr ignored");
  property p_glitch; (system_reset_n && $fell(master_clear_pin_n)) ##1 master_clear_pin_n
    |-> system_reset_n [*4]; endproperty
  a_glitch: assert property (p_glitch) else $error("short pulse reset");
  property p_no_mon; cfg.switch_monitor[1] |-> !clock_fail_trap; endproperty
  a_no_mon: assert property (p_no_mon) else $error("trap with monitor off");
  property p_mirror; cfg.switch_monitor[1] && system_reset_n |-> sel_group == cfg.osc_group;
  endproperty
  a_mirror: assert property (p_mirror) else $error("group not from config");
endmodule

// file: test/csw_osc_model.sv
// oscillator sources: clock edges, low-power ticks and phase pulses
`timescale 1ns/1ns
module csw_osc_model
  import csw_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     stall,
  output csw_osc_stat_t st,
  output logic          q1
);
  logic [1:0] ph = 2'h0;
  always @(posedge clk) ph <= ph + 2'h1;
  // a stalled oscillator stops its edges and its running flag
  assign st = '{sysclk_tick: !stall, low_power_rc_osc_tick: ph == 2'h0, osc_running: !stall,
                ost_done: 1'h1, pll_used: 1'h0, pll_lock: 1'h0, group_ready: 4'hF};
  assign q1 = ph == 2'h2;
endmodule

// file: test/tb_clock_switch_failsafe_reset.sv
// self-checking bench for the clock switch and reset sequencer
`timescale 1ns/1ns
module tb_clock_switch_failsafe_reset;
  import csw_pkg::*;
  logic          clk = 1'h0;
  logic          rstn = 1'h0;
  csw_axi_req_t  rq = '0;
  csw_axi_rsp_t  rs;
  csw_cfg_t      cfg = '0;
  csw_rst_evt_t  ev = '0;
  csw_osc_stat_t st;
  logic          q1, oe, lp, trap, srn;
  logic          stall = 1'h0;
  logic          slp = 1'h0;
  logic          pin = 1'h1;
  logic [1:0]    grp, rsc;
  logic [3:0]    pm;
  logic [31:0]   rdv;
  int            error_cnt = 0;
  int            num_checks = 0;
  always #10 clk = ~clk;
  csw_osc_model u_osc (.clk(clk), .stall(stall), .st(st), .q1(q1));
  csw_clock_reset #(.POWER_UP_DELAY_TIMER_SHORT(20), .POWER_UP_DELAY_TIMER_MID(40), .POWER_UP_DELAY_TIMER_LONG(80)) uut (
    .clk(clk), .rstn(rstn), .axi_req(rq), .axi_rsp(rs), .cfg(cfg), .rst_evt(ev),
    .osc_stat(st), .master_clear_pin_n(pin), .first_quarter_phase(q1),
    .sleep_mode(slp), .idle_mode(1'h0), .soft_watchdog_enable(1'h0),
    .master_clear_pin_oe(oe), .low_power_rc_osc_en(lp), .sel_group(grp),
    .sel_primary_mode(pm), .clock_fail_trap(trap), .system_reset_n(srn));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits for system release (t=0) or a trap (t=1)
  task automatic wt(input bit t, input int lim);
    int n;
    for (n = 0; n < lim && (t ? trap : srn) !== 1'h1; n++) @(posedge clk);
    if (n >= lim) begin
      chk("wait", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  task automatic bus(input bit w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    rq.awaddr <= a;
    rq.araddr <= a;
    rq.wdata <= d;
    rq.wstrb <= s;
    rq.awvalid <= w;
    rq.wvalid <= w;
    rq.bready <= w;
    rq.arvalid <= !w;
    rq.rready <= !w;
    do begin
      @(posedge clk);
      n++;
      if (rs.awready) rq.awvalid <= 1'h0;
      if (rs.wready) rq.wvalid <= 1'h0;
      if (rs.arready) rq.arvalid <= 1'h0;
    end while ((w ? rs.bvalid : rs.rvalid) !== 1'h1 && n < 50);
    rdv = rs.rdata;
    rsc = w ? rs.bresp : rs.rresp;
    rq.bready <= 1'h0;
    rq.rready <= 1'h0;
    @(posedge clk);
    if (n >= 50) wt(0, 0);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, 4'h0);
    chk(nm, e, rdv);
  endtask
  task automatic por(input csw_cfg_t c);
    cfg <= c;
    rstn <= 1'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    wt(0, 2000);
  endtask
  // k=0 reset instruction, otherwise pin held low for k cycles
  task automatic warm(input int k, input logic [31:0] e);
    bus(1'h1, RESET_CAUSE_ADDR, 32'h0, 4'h3);
    if (k == 0) ev.reset_instr <= 1'h1;
    else pin <= 1'h0;
    repeat ((k > 0) ? k : 1) @(posedge clk);
    ev <= '0;
    pin <= 1'h1;
    repeat (2) @(posedge clk);
    wt(0, 2000);
    rchk("cause", RESET_CAUSE_ADDR, e);
  endtask
  initial begin
    por('{2'h3, 4'h5, SMS_BOTH, 2'h1, 1'h0});
    rchk("cause", RESET_CAUSE_ADDR, 32'h3);
    rchk("osc", OSC_CTRL_ADDR, 32'h3300);
    chk("mode", 32'h5, {28'h0, pm});
    chk("low_power_rc_osc", 32'h1, {31'h0, lp});
    bus(1'h1, OSC_CTRL_ADDR, 32'h1, 4'h1);
    rchk("locked", OSC_CTRL_ADDR, 32'h3300);
    bus(1'h1, OSC_CTRL_ADDR, 32'h7800, 4'h2);
    bus(1'h1, OSC_CTRL_ADDR, 32'h9A00, 4'h2);
    bus(1'h1, OSC_CTRL_ADDR, 32'h0200, 4'h2);
    rchk("new_osc_group", OSC_CTRL_ADDR, 32'h3200);
    bus(1'h1, OSC_CTRL_ADDR, 32'h46, 4'h1);
    bus(1'h1, OSC_CTRL_ADDR, 32'h57, 4'h1);
    bus(1'h1, OSC_CTRL_ADDR, 32'h1, 4'h1);
    rchk("switch", OSC_CTRL_ADDR, 32'h2200);
    chk("group", 32'h2, {30'h0, grp});
    stall <= 1'h1;
    wt(1, 100);
    stall <= 1'h0;
    rchk("fail", OSC_CTRL_ADDR, 32'h1208);
    chk("frc", 32'h1, {30'h0, grp});
    // sleep with monitor on, watchdog off, fast rc in use: low-power osc may stop
    slp <= 1'h1;
    repeat (2) @(posedge clk);
    chk("sleep low_power_rc_osc", 32'h0, {31'h0, lp});
    slp <= 1'h0;
    bus(1'h0, 32'h10, 32'h0, 4'h0);
    chk("resp", {30'h0, RESP_SLVERR}, {30'h0, rsc});
    warm(0, 32'h40);
    warm(1, 32'h0);
    warm(12, 32'h80);
    por('{2'h0, 4'h2, 2'h2, 2'h0, 1'h0});
    chk("direct", 32'h0, {30'h0, grp});
    chk("low_power_rc_osc off", 32'h0, {31'h0, lp});
    stall <= 1'h1;
    repeat (40) @(posedge clk);
    stall <= 1'h0;
    rchk("no fail", OSC_CTRL_ADDR, 32'h0);
    tally_and_finish();
  end
endmodule
bind csw_clock_reset csw_clock_reset_props u_props (.*);
